// File: bfp_pkg.sv
// Constants and carrier types for the buck fault-protection block.
// Assumes analog front ends deliver digitized codes on the switching clock.
`default_nettype none
package bfp_pkg;
    localparam int CODE_W = 10;
    // Sense codes: 1 lsb = 1 mV
    localparam logic [CODE_W-1:0] UV_MV = 10'h258;       // 600 mV
    localparam logic [CODE_W-1:0] OV_MV = 10'h3e8;       // 1000 mV
    localparam logic [CODE_W-1:0] DIS_MV = 10'h190;      // 400 mV
    localparam logic [CODE_W-1:0] MISS_MV = 10'h1f4;     // 500 mV
    localparam logic [CODE_W-1:0] PG_OUT_LO = 10'h2d0;   // 720 mV, -10%
    localparam logic [CODE_W-1:0] PG_OUT_HI = 10'h370;   // 880 mV, +10%
    localparam logic [CODE_W-1:0] PG_IN_LO = 10'h2f0;    // 752 mV, -6%
    localparam logic [CODE_W-1:0] PG_IN_HI = 10'h350;    // 848 mV, +6%
    localparam int CLK_HZ = 50000000;
    localparam int CAL_TIME_US = 5500;
    localparam int CAL_CYC = CAL_TIME_US * (CLK_HZ / 1000000);
    localparam int SS_TIME_US = 3500;
    localparam int SS_CYC = SS_TIME_US * (CLK_HZ / 1000000);
    localparam int OV_ARM_CYC = 64;
    localparam logic [1:0] OC_PERSIST = 2'h2;
    localparam int CNT_W = 20;

    typedef enum logic [2:0] {
        BFP_OFF = 3'h0,
        BFP_CAL = 3'h1,
        BFP_SS = 3'h2,
        BFP_RUN = 3'h3,
        BFP_OVDIS = 3'h4,
        BFP_LATCH = 3'h5
    } bfp_state_t;

    typedef struct packed {
        logic high_drive;
        logic low_drive;
    } bfp_drive_t;

    typedef struct packed {
        logic oc_latched;
        logic uv_latched;
        logic ov_latched;
        logic miss_res;
    } bfp_fault_t;
endpackage
`default_nettype wire

// File: bfp_sync.sv
// Three-stage input synchroniser with agreement filter for pin levels.
// Assumes a single clock; first stage feeds only the second.
`default_nettype none
module bfp_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output var logic dout
);
    logic s1_q, s2_q, s3_q, out_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                out_q <= s3_q;
            end
        end
    end
    assign dout = out_q;
endmodule
`default_nettype wire

// File: bfp_core.sv
// Buck fault protection: calibration, OC/UV/OV latch-off, power-good.
// Assumes sense and drop codes are sampled on clk; rst is power-on reset.
`default_nettype none
module bfp_core #(
    parameter int CAL_CYCLES = bfp_pkg::CAL_CYC,
    parameter int SS_CYCLES = bfp_pkg::SS_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable_pin,
    input wire logic [bfp_pkg::CODE_W-1:0] low_drive_oc_set_pin,
    input wire logic [bfp_pkg::CODE_W-1:0] low_side_drop,
    input wire logic period_end,
    input wire logic [bfp_pkg::CODE_W-1:0] output_sense_input,
    input wire logic [bfp_pkg::CODE_W-1:0] soft_start_level,
    input wire logic high_drive_req,
    input wire logic low_drive_req,
    output var logic cal_current_en,
    output var bfp_pkg::bfp_drive_t drive,
    output var bfp_pkg::bfp_fault_t faults,
    output var logic power_good_output_o,
    output var logic power_good_output_oe
);
    import bfp_pkg::*;

    bfp_state_t state_q, state_d;
    logic en_s;
    logic [CNT_W-1:0] cnt_q;
    logic [6:0] ov_cnt_q;
    logic [CODE_W-1:0] oc_ref_q;
    logic [1:0] oc_run_q;
    logic oc_arm_q, ov_arm_q, uv_arm_q, pg_q, pg_oe_q, cal_cur_q;
    logic pg_d;
    bfp_drive_t drive_q;
    bfp_fault_t fault_q;

    bfp_sync u_en_sync (.clk(clk), .rst(rst), .din(enable_pin), .dout(en_s));

    wire cal_done = (cnt_q == CNT_W'(CAL_CYCLES - 1));
    wire ss_done = (cnt_q == CNT_W'(SS_CYCLES - 1));
    wire miss_res = (low_drive_oc_set_pin > MISS_MV);
    wire oc_hit = oc_arm_q && period_end && low_drive_req && (low_side_drop > oc_ref_q);
    wire oc_trip = oc_hit && (oc_run_q == OC_PERSIST);
    wire uv_trip = uv_arm_q && (output_sense_input < UV_MV);
    wire ov_trip = ov_arm_q && (output_sense_input > OV_MV);
    wire switching = (state_q == BFP_SS) || (state_q == BFP_RUN);
    wire pg_outside = (output_sense_input < PG_OUT_LO) || (output_sense_input > PG_OUT_HI);
    wire pg_inside = (output_sense_input >= PG_IN_LO) && (output_sense_input <= PG_IN_HI);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BFP_OFF: begin
                if (en_s) state_d = BFP_CAL;
            end
            BFP_CAL: begin
                if (ov_trip) state_d = BFP_OVDIS;
                else if (!en_s) state_d = BFP_OFF;
                else if (cal_done && !miss_res) state_d = BFP_SS;
            end
            BFP_SS, BFP_RUN: begin
                if (ov_trip) state_d = BFP_OVDIS;
                else if (oc_trip || uv_trip) state_d = BFP_LATCH;
                else if (!en_s) state_d = BFP_OFF;
                else if (state_q == BFP_SS && ss_done) state_d = BFP_RUN;
            end
            BFP_OVDIS: begin
                if (output_sense_input <= DIS_MV) state_d = BFP_LATCH;
            end
            BFP_LATCH: state_d = BFP_LATCH;
            default: state_d = BFP_LATCH;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= BFP_OFF;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
        end
    end

    // Calibration: test current on, code captured at phase end
    always_ff @(posedge clk) begin
        if (rst) begin
            oc_ref_q <= '0;
            cal_cur_q <= 1'b0;
        end else begin
            cal_cur_q <= (state_d == BFP_CAL);
            if (state_q == BFP_CAL && cal_done) oc_ref_q <= low_drive_oc_set_pin;
        end
    end

    // Protection arming
    always_ff @(posedge clk) begin
        if (rst) begin
            ov_cnt_q <= '0;
            ov_arm_q <= 1'b0;
            oc_arm_q <= 1'b0;
            uv_arm_q <= 1'b0;
            oc_run_q <= '0;
        end else begin
            if (state_q == BFP_OFF) begin
                ov_cnt_q <= '0;
                ov_arm_q <= 1'b0;
            end else if (ov_cnt_q != 7'(OV_ARM_CYC)) begin
                ov_cnt_q <= ov_cnt_q + 1'b1;
            end else begin
                ov_arm_q <= 1'b1;
            end
            if (!switching) oc_arm_q <= 1'b0;
            else if (soft_start_level > output_sense_input) oc_arm_q <= 1'b1;
            uv_arm_q <= (state_d == BFP_RUN);
            // Count consecutive period-end hits; a clean period resets
            if (period_end) oc_run_q <= oc_hit ? ((oc_run_q == OC_PERSIST) ? oc_run_q : oc_run_q + 1'b1) : '0;
        end
    end

    // Drivers and faults
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_q <= '0;
            fault_q <= '0;
        end else begin
            drive_q.high_drive <= (state_d == BFP_SS || state_d == BFP_RUN) && high_drive_req;
            drive_q.low_drive <= (state_d == BFP_OVDIS) ||
                ((state_d == BFP_SS || state_d == BFP_RUN) && low_drive_req);
            if (switching && oc_trip && !ov_trip) fault_q.oc_latched <= 1'b1;
            if (switching && uv_trip && !ov_trip) fault_q.uv_latched <= 1'b1;
            if (state_d == BFP_OVDIS) fault_q.ov_latched <= 1'b1;
            // Sticky so a stalled calibration stays visible to the outside
            if (state_q == BFP_CAL && cal_done && miss_res) fault_q.miss_res <= 1'b1;
        end
    end

    // Power-good with hysteresis; open drain, pulled low when bad
    always_comb begin
        pg_d = pg_q;
        if (state_d != BFP_RUN) begin
            pg_d = 1'b0;
        end else if (state_q != BFP_RUN) begin
            pg_d = 1'b1;
        end else if (pg_outside) begin
            pg_d = 1'b0;
        end else if (pg_inside) begin
            pg_d = 1'b1;
        end
    end
    // Enable register holds the inverse of the good flag so the pin leaves a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            pg_q <= 1'b0;
            pg_oe_q <= 1'b1;
        end else begin
            pg_q <= pg_d;
            pg_oe_q <= !pg_d;
        end
    end

    assign cal_current_en = cal_cur_q;
    assign drive = drive_q;
    assign faults = fault_q;
    assign power_good_output_o = 1'b0;
    assign power_good_output_oe = pg_oe_q;

    property p_latch_drv_off;
        @(posedge clk) disable iff (rst) (state_q == BFP_LATCH) |=> (drive_q == '0);
    endproperty
    a_latch_drv_off: assert property (p_latch_drv_off) else $error("drivers on while latched");
    property p_latch_sticky;
        @(posedge clk) disable iff (rst) (state_q == BFP_LATCH) |=> (state_q == BFP_LATCH);
    endproperty
    a_latch_sticky: assert property (p_latch_sticky) else $error("latch left");
    property p_ov_low_on;
        @(posedge clk) disable iff (rst) (switching && ov_trip) |=> drive_q.low_drive && !drive_q.high_drive;
    endproperty
    a_ov_low_on: assert property (p_ov_low_on) else $error("ov drive wrong");
    property p_ov_release;
        @(posedge clk) disable iff (rst)
            (state_q == BFP_OVDIS && output_sense_input <= DIS_MV) |=> (state_q == BFP_LATCH) ##1 !drive_q.low_drive;
    endproperty
    a_ov_release: assert property (p_ov_release) else $error("ov discharge end wrong");
    property p_uv_latch;
        @(posedge clk) disable iff (rst) (switching && uv_trip && !ov_trip) |=> (state_q == BFP_LATCH);
    endproperty
    a_uv_latch: assert property (p_uv_latch) else $error("uv not latched");
    property p_oc_latch;
        @(posedge clk) disable iff (rst) (switching && oc_trip && !ov_trip) |=> fault_q.oc_latched;
    endproperty
    a_oc_latch: assert property (p_oc_latch) else $error("oc not latched");
    // Drive flops load from the next state, so check them in the same cycle
    property p_cal_off;
        @(posedge clk) disable iff (rst) (state_q == BFP_CAL) |-> (drive_q == '0);
    endproperty
    a_cal_off: assert property (p_cal_off) else $error("drive during calibration");
    property p_pg_pre;
        @(posedge clk) disable iff (rst) (state_q != BFP_RUN) |-> power_good_output_oe;
    endproperty
    a_pg_pre: assert property (p_pg_pre) else $error("power-good early");
    property p_miss;
        @(posedge clk) disable iff (rst) (state_q == BFP_CAL && miss_res && en_s && !ov_trip) |=> (state_q == BFP_CAL);
    endproperty
    a_miss: assert property (p_miss) else $error("left calibration with missing resistor");
    property p_cal_cur;
        @(posedge clk) disable iff (rst) (state_q == BFP_CAL) |-> cal_current_en;
    endproperty
    a_cal_cur: assert property (p_cal_cur) else $error("test current off in calibration");
    property p_ref_hold;
        @(posedge clk) disable iff (rst) switching |=> $stable(oc_ref_q);
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("overcurrent reference moved");
    property p_pg_drop;
        @(posedge clk) disable iff (rst) (state_q == BFP_RUN && pg_outside) |=> power_good_output_oe;
    endproperty
    a_pg_drop: assert property (p_pg_drop) else $error("power-good kept outside window");
    property p_pg_back;
        @(posedge clk) disable iff (rst)
            (state_q == BFP_RUN && state_d == BFP_RUN && pg_inside) |=> !power_good_output_oe;
    endproperty
    a_pg_back: assert property (p_pg_back) else $error("power-good held low inside window");

    c_run: cover property (@(posedge clk) disable iff (rst) state_q == BFP_SS ##1 state_q == BFP_RUN);
    c_ov: cover property (@(posedge clk) disable iff (rst) state_q == BFP_OVDIS);
    c_oc: cover property (@(posedge clk) disable iff (rst) fault_q.oc_latched);
    c_uv: cover property (@(posedge clk) disable iff (rst) fault_q.uv_latched);
endmodule
`default_nettype wire

// File: bfp_stage_model.sv
// Model of the board side: sense divider feeding the output sense input, and
// the power-good pull-up. Assumes the bench sets the divided output level.
`default_nettype none
module bfp_stage_model (
    input wire logic clk,
    input wire logic [bfp_pkg::CODE_W-1:0] sense_set,
    input wire logic pg_o,
    input wire logic pg_oe,
    output var logic [bfp_pkg::CODE_W-1:0] sense,
    output wire logic pg_line
);
    timeunit 1ns;
    timeprecision 1ps;
    import bfp_pkg::*;
    // One cycle of filter lag, as a real divider never answers instantly
    always_ff @(posedge clk) begin
        sense <= sense_set;
    end
    // Released pin reads high through the board pull-up
    assign pg_line = pg_oe ? pg_o : 1'b1;
endmodule
`default_nettype wire

// File: tb_buck_fault_protection.sv
// Self-checking bench for the buck fault-protection core.
// Assumes short calibration and soft-start counts; rst stands in for supply cycling.
`default_nettype none
module tb_buck_fault_protection;
    timeunit 1ns;
    timeprecision 1ps;
    import bfp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, pend = 1'b0, hreq = 1'b1, lreq = 1'b1;
    logic [CODE_W-1:0] setpin = 10'h0c8, drop = 10'h000, sset = 10'h320, ss_lvl = 10'h3ff;
    logic [CODE_W-1:0] sense;
    logic cal_en, pg_o, pg_oe;
    wire logic pg_line;
    bfp_drive_t drv;
    bfp_fault_t flt;
    int fail_count = 0;
    int comparisons = 0;

    always #10 clk = ~clk;

    bfp_core #(.CAL_CYCLES(20), .SS_CYCLES(30)) u_dut (.clk(clk), .rst(rst), .enable_pin(en),
        .low_drive_oc_set_pin(setpin), .low_side_drop(drop), .period_end(pend),
        .output_sense_input(sense), .soft_start_level(ss_lvl), .high_drive_req(hreq),
        .low_drive_req(lreq), .cal_current_en(cal_en), .drive(drv), .faults(flt),
        .power_good_output_o(pg_o), .power_good_output_oe(pg_oe));
    bfp_stage_model u_stage (.clk(clk), .sense_set(sset), .pg_o(pg_o), .pg_oe(pg_oe),
        .sense(sense), .pg_line(pg_line));

    task tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #2;
        end
    endtask
    task chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task wait_pg(input logic lvl, input int lim);
        for (int i = 0; i < lim && pg_line !== lvl; i++) tick(1);
        if (pg_line !== lvl) begin
            fail_count++;
            $display("BAD %0t power-good wait expired", $time);
            results();
        end
    endtask
    // Supply cycling is the only way out of a latch-off
    task boot(input logic [CODE_W-1:0] pin);
        rst = 1'b1; en = 1'b0; setpin = pin; sset = 10'h320; drop = 10'h000;
        tick(5);
        rst = 1'b0;
        en = 1'b1;
    endtask
    task hit(input logic [CODE_W-1:0] d);
        drop = d; pend = 1'b1;
        tick(1);
        pend = 1'b0;
        tick(2);
    endtask

    task t_start;
        boot(10'h0c8);
        tick(10);
        chk(drv === 2'b00 && cal_en === 1'b1 && pg_line === 1'b0, "calibration phase");
        tick(25);
        chk(drv.high_drive === 1'b1 && cal_en === 1'b0 && pg_line === 1'b0, "soft-start phase");
        wait_pg(1'b1, 200);
        chk(drv.high_drive === 1'b1 && flt === 4'h0, "run entry");
        boot(10'h258);
        tick(150);
        chk(drv === 2'b00 && pg_line === 1'b0 && flt.miss_res === 1'b1, "missing resistor left calibration");
        boot(10'h1f4);
        wait_pg(1'b1, 200);
        $display("test start done");
    endtask
    task t_oc;
        ss_lvl = 10'h000;
        boot(10'h0c8);
        wait_pg(1'b1, 200);
        hit(10'h0c9);
        hit(10'h0c9);
        hit(10'h0c9);
        chk(flt.oc_latched === 1'b0 && drv === 2'b11, "tripped before soft-start passed pre-bias");
        ss_lvl = 10'h3ff;
        lreq = 1'b0;
        tick(1);
        hit(10'h0c9);
        hit(10'h0c9);
        hit(10'h0c9);
        chk(flt.oc_latched === 1'b0 && drv === 2'b10, "tripped while low side off");
        lreq = 1'b1;
        tick(1);
        hit(10'h0c9); hit(10'h0c9); hit(10'h064); hit(10'h0c9); hit(10'h0c9);
        chk(flt.oc_latched === 1'b0 && drv === 2'b11, "tripped without persistence");
        hit(10'h0c9);
        chk(flt.oc_latched === 1'b1 && drv === 2'b00, "no overcurrent trip");
        hit(10'h000);
        tick(10);
        chk(flt.oc_latched === 1'b1 && drv === 2'b00, "overcurrent latch lost");
        $display("test overcurrent done");
    endtask
    task t_ov;
        boot(10'h0c8);
        tick(15);
        sset = 10'h3e9;
        tick(8);
        chk(drv === 2'b00 && flt === 4'h0, "overvoltage acted before arming");
        sset = 10'h320;
        wait_pg(1'b1, 200);
        tick(20);
        sset = 10'h3e8;
        tick(4);
        chk(drv === 2'b11 && flt === 4'h0, "overvoltage at limit");
        sset = 10'h3e9;
        tick(3);
        chk(drv === 2'b01 && flt.ov_latched === 1'b1, "overvoltage response");
        sset = 10'h191;
        tick(5);
        chk(drv === 2'b01, "discharge ended early");
        sset = 10'h190;
        tick(4);
        chk(drv === 2'b00, "discharge not ended");
        sset = 10'h320;
        tick(8);
        chk(drv === 2'b00 && flt.ov_latched === 1'b1, "overvoltage latch lost");
        $display("test overvoltage done");
    endtask
    task t_pg_uv;
        boot(10'h0c8);
        wait_pg(1'b1, 200);
        sset = 10'h2cf;
        tick(4);
        chk(pg_line === 1'b0 && flt === 4'h0, "outer window");
        sset = 10'h2ef;
        tick(4);
        chk(pg_line === 1'b0, "released outside inner window");
        sset = 10'h320;
        tick(4);
        chk(pg_line === 1'b1, "not released inside inner window");
        sset = 10'h257;
        tick(4);
        chk(drv === 2'b00 && flt.uv_latched === 1'b1, "undervoltage response");
        sset = 10'h320;
        tick(8);
        chk(drv === 2'b00 && flt.uv_latched === 1'b1, "undervoltage latch lost");
        $display("test undervoltage done");
    endtask

    initial begin
        t_start();
        t_oc();
        t_ov();
        t_pg_uv();
        results();
    end
endmodule
`default_nettype wire
